// File: rtl/ltc_pkg.sv
// Package: register map, field positions and timing constants
package ltc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] DRV_CTRL_ADDR  = 16'h1300;
  localparam logic [15:0] ALM_STAT_ADDR  = 16'h1303;
  localparam logic [15:0] TX_CTRL_ADDR   = 16'h1304;
  localparam logic [15:0] IRQ_STAT_ADDR  = 16'h1310;
  localparam logic [15:0] IRQ_EN_ADDR    = 16'h1311;
  localparam logic [15:0] IRQ_CLR_ADDR   = 16'h1312;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BUILD_OUT_BIT  = 0;
  localparam int ALL_ONES_BIT   = 2;
  localparam int INT_MON_BIT    = 5;
  localparam int DRV_EN_BIT     = 0;
  localparam int FAULT_BIT      = 0;

  localparam logic [7:0] TX_CTRL_MASK  = 8'h25;
  localparam logic [7:0] DRV_CTRL_MASK = 8'h01;
  localparam logic [7:0] IRQ_MASK      = 8'h01;
  localparam logic [7:0] RESET_VAL     = 8'h00;

  // ----------------------------------------------------------------------
  // Timing: fault after this many bit periods without a pulse
  // ----------------------------------------------------------------------
  localparam int          SILENT_BITS = 128;
  localparam logic [7:0]  SILENT_MAX  = 8'(SILENT_BITS - 1);
  localparam logic [7:0]  CNT_ZERO    = 8'h00;
  localparam logic [7:0]  CNT_ONE     = 8'h01;

endpackage : ltc_pkg

// File: rtl/ltc_mon_if.sv
// Interface: drive monitor controls and status
`timescale 1ns/1ps
interface ltc_mon_if;
  logic mode_internal;
  logic line_active;
  logic pulse_seen;
  logic fault;
  logic fault_set;
  logic fault_clr;
  modport ctl (output mode_internal, output line_active, output pulse_seen,
               input fault, input fault_set, input fault_clr);
  modport mon (input mode_internal, input line_active, input pulse_seen,
               output fault, output fault_set, output fault_clr);
endinterface : ltc_mon_if

// File: rtl/ltc_drive_mon.sv
// Transmit drive monitor: silence counter and fault state
`timescale 1ns/1ps
module ltc_drive_mon (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Monitor link
  ltc_mon_if.mon    mon
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OK    = 2'b01,
    ST_FAULT = 2'b10
  } ltc_mon_st_e;

  ltc_mon_st_e state_r;
  logic [7:0]  silent_r;
  logic        set_r;
  logic        clr_r;
  logic        expire;

  assign expire = (silent_r == ltc_pkg::SILENT_MAX) && !mon.pulse_seen;

  // ----------------------------------------------------------------------
  // Silence counter, reset by any pulse
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      silent_r <= ltc_pkg::CNT_ZERO;
    end else if (mon.pulse_seen || state_r == ST_FAULT) begin
      silent_r <= ltc_pkg::CNT_ZERO;
    end else if (silent_r != ltc_pkg::SILENT_MAX) begin
      silent_r <= silent_r + ltc_pkg::CNT_ONE; // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Fault state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_OK;
      set_r   <= 1'b0;
      clr_r   <= 1'b0;
    end else begin
      set_r <= 1'b0;
      clr_r <= 1'b0;
      case (state_r)
        ST_OK: begin
          if (expire) begin
            state_r <= ST_FAULT; // [R14]
            set_r   <= 1'b1;
          end
        end
        ST_FAULT: begin
          if (mon.pulse_seen) begin
            state_r <= ST_OK; // [R15]
            clr_r   <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_OK;
        end
      endcase
    end
  end

  assign mon.fault     = (state_r == ST_FAULT);
  assign mon.fault_set = set_r;
  assign mon.fault_clr = clr_r;

endmodule : ltc_drive_mon

// File: rtl/ltc_top.sv
// Transmit line output control: all-ones, build-out, driver, drive monitor
// Functional notes
// [R1] Route register controls to shaping and driver
// [R2] All-ones force replaces framer data
// [R3] Force clear passes framer data unchanged
// [R4] Build-out bit zero enables shaping
// [R5] Build-out bit one sends square pulses
// [R6] Software: shaping below 225 feet
// [R7] Driver on needs register bit and pin
// [R8] Driver bit zero tristates both outputs
// [R9] Board holds driver pin high
// [R10] Redundancy software writes driver register
// [R11] External or internal drive monitoring
// [R12] External mode watches monitor pin pair
// [R13] Software: bit five zero selects external
// [R14] 128 silent bits declare fault, interrupt
// [R15] One pulse clears the fault
// [R16] Unused bits read zero, reset zero
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ltc_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Register port
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Framer data in (dual-rail, one bit period per clock)
  input  wire logic        FRM_POS,
  input  wire logic        FRM_NEG,
  // Driver enable pin
  input  wire logic        DRV_EN_PIN,
  // Monitor pins
  input  wire logic        MON_TIP_IN,
  input  wire logic        MON_RING_IN,
  // Line outputs
  output logic             TX_LINE_TIP_OUT,
  output logic             TX_LINE_RING_OUT,
  output logic             TX_LINE_TIP_OE,
  output logic             TX_LINE_RING_OE,
  // Shaping stage control
  output logic             BUILD_OUT_BYPASS,
  // Interrupt, active low
  output logic             IRQ_N
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] tx_ctrl_r;
  logic [7:0] drv_ctrl_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_en_r;
  logic [7:0] rdata_nxt;
  logic       ones_phase_r;
  logic       tip_nxt;
  logic       ring_nxt;
  logic       drv_on;

  ltc_mon_if mon_if ();

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  // ----------------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_ctrl_r  <= ltc_pkg::RESET_VAL; // [R16]
      drv_ctrl_r <= ltc_pkg::RESET_VAL; // [R16]
    end else if (WR) begin
      if (hit(ADDR, ltc_pkg::TX_CTRL_ADDR)) begin
        tx_ctrl_r <= WDATA & ltc_pkg::TX_CTRL_MASK; // [R16]
      end
      if (hit(ADDR, ltc_pkg::DRV_CTRL_ADDR)) begin
        drv_ctrl_r <= WDATA & ltc_pkg::DRV_CTRL_MASK; // [R16]
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_en_r <= ltc_pkg::RESET_VAL;
    end else if (WR && hit(ADDR, ltc_pkg::IRQ_EN_ADDR)) begin
      irq_en_r <= WDATA & ltc_pkg::IRQ_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status: set on fault change, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_stat_r <= ltc_pkg::RESET_VAL;
    end else begin
      if (WR && hit(ADDR, ltc_pkg::IRQ_CLR_ADDR)) begin
        irq_stat_r[ltc_pkg::FAULT_BIT] <= 1'b0;
      end
      if (mon_if.fault_set || mon_if.fault_clr) begin
        irq_stat_r[ltc_pkg::FAULT_BIT] <= 1'b1; // [R14]
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= ~|(irq_stat_r & irq_en_r); // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = ltc_pkg::RESET_VAL;
    if (hit(ADDR, ltc_pkg::TX_CTRL_ADDR)) begin
      rdata_nxt = tx_ctrl_r;
    end else if (hit(ADDR, ltc_pkg::DRV_CTRL_ADDR)) begin
      rdata_nxt = drv_ctrl_r;
    end else if (hit(ADDR, ltc_pkg::ALM_STAT_ADDR)) begin
      rdata_nxt[ltc_pkg::FAULT_BIT] = mon_if.fault;
    end else if (hit(ADDR, ltc_pkg::IRQ_STAT_ADDR)) begin
      rdata_nxt = irq_stat_r;
    end else if (hit(ADDR, ltc_pkg::IRQ_EN_ADDR)) begin
      rdata_nxt = irq_en_r;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RDATA <= ltc_pkg::RESET_VAL;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end else begin
      RDATA <= ltc_pkg::RESET_VAL;
    end
  end

  // ----------------------------------------------------------------------
  // Line data path
  // ----------------------------------------------------------------------
  // All-ones alternates polarity so every bit is a mark
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ones_phase_r <= 1'b0;
    end else begin
      ones_phase_r <= ~ones_phase_r;
    end
  end

  always_comb begin
    if (tx_ctrl_r[ltc_pkg::ALL_ONES_BIT]) begin
      tip_nxt  = ~ones_phase_r; // [R2]
      ring_nxt = ones_phase_r;  // [R2]
    end else begin
      tip_nxt  = FRM_POS; // [R3]
      ring_nxt = FRM_NEG; // [R3]
    end
  end

  assign drv_on = drv_ctrl_r[ltc_pkg::DRV_EN_BIT] & DRV_EN_PIN; // [R7]

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      TX_LINE_TIP_OUT  <= 1'b0;
      TX_LINE_RING_OUT <= 1'b0;
      TX_LINE_TIP_OE   <= 1'b0;
      TX_LINE_RING_OE  <= 1'b0;
      BUILD_OUT_BYPASS <= 1'b0;
    end else begin
      TX_LINE_TIP_OUT  <= tip_nxt & drv_on;  // [R1]
      TX_LINE_RING_OUT <= ring_nxt & drv_on; // [R1]
      TX_LINE_TIP_OE   <= drv_on;            // [R8]
      TX_LINE_RING_OE  <= drv_on;            // [R8]
      BUILD_OUT_BYPASS <= tx_ctrl_r[ltc_pkg::BUILD_OUT_BIT]; // [R4] [R5]
    end
  end

  // ----------------------------------------------------------------------
  // Drive monitor
  // ----------------------------------------------------------------------
  // Internal mode watches the driven line, external the monitor pins
  assign mon_if.mode_internal = tx_ctrl_r[ltc_pkg::INT_MON_BIT]; // [R11]
  assign mon_if.line_active   = TX_LINE_TIP_OUT | TX_LINE_RING_OUT;
  assign mon_if.pulse_seen    = mon_if.mode_internal ? mon_if.line_active :
                                (MON_TIP_IN | MON_RING_IN); // [R12]

  ltc_drive_mon u_mon (
    .clk (CLK),
    .rst (RST),
    .mon (mon_if.mon)
  );

endmodule : ltc_top

// File: verif/ltc_properties.sv
// Checker: port properties of the line control top
`timescale 1ns/1ps
module ltc_properties (
  // Clock, reset, register port
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  // Line side
  input wire logic        FRM_POS,
  input wire logic        FRM_NEG,
  input wire logic        DRV_EN_PIN,
  input wire logic        TX_LINE_TIP_OUT,
  input wire logic        TX_LINE_RING_OUT,
  input wire logic        TX_LINE_TIP_OE,
  input wire logic        TX_LINE_RING_OE,
  input wire logic        BUILD_OUT_BYPASS,
  input wire logic        IRQ_N
);
  // ----
  // Register mirrors
  // ----
  logic [7:0] txc_r;
  logic       drv_r;
  logic       ien_r;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) txc_r <= 8'h00;
    else if (WR && ADDR == ltc_pkg::TX_CTRL_ADDR) txc_r <= WDATA & 8'h25;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) drv_r <= 1'b0;
    else if (WR && ADDR == ltc_pkg::DRV_CTRL_ADDR) drv_r <= WDATA[0];
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ien_r <= 1'b0;
    else if (WR && ADDR == ltc_pkg::IRQ_EN_ADDR) ien_r <= WDATA[0];
  end
  logic aones;
  logic bo;
  assign aones = txc_r[2];
  assign bo = txc_r[0];
  // ----
  // Properties
  // ----
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence tx_read;
    RD && ADDR == ltc_pkg::TX_CTRL_ADDR;
  endsequence
  reg_read_a: assert property (tx_read |=> RDATA == $past(txc_r))
    else $error("tx control read back wrong");
  rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not zero when idle");
  oe_pair_a: assert property (TX_LINE_TIP_OE == TX_LINE_RING_OE)
    else $error("output enables differ");
  off_quiet_a: assert property (!TX_LINE_TIP_OE |->
    !TX_LINE_TIP_OUT && !TX_LINE_RING_OUT) else $error("data while off");
  oe_cause_a: assert property (1'b1 |=>
    TX_LINE_TIP_OE == $past(DRV_EN_PIN && drv_r)) else $error("enable wrong");
  pass_data_a: assert property (TX_LINE_TIP_OE && !$past(aones) |->
    TX_LINE_TIP_OUT == $past(FRM_POS) && TX_LINE_RING_OUT == $past(FRM_NEG))
    else $error("framer data altered");
  all_ones_a: assert property (TX_LINE_TIP_OE && $past(aones) |->
    TX_LINE_TIP_OUT != TX_LINE_RING_OUT) else $error("no mark forced");
  build_out_a: assert property ($stable(bo) |-> BUILD_OUT_BYPASS == bo)
    else $error("build-out control wrong");
  irq_mask_a: assert property (!IRQ_N |-> $past(ien_r))
    else $error("interrupt while disabled");
endmodule // ltc_properties

bind ltc_top ltc_properties ltc_properties_inst (
  .CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .FRM_POS, .FRM_NEG,
  .DRV_EN_PIN, .TX_LINE_TIP_OUT, .TX_LINE_RING_OUT, .TX_LINE_TIP_OE,
  .TX_LINE_RING_OE, .BUILD_OUT_BYPASS, .IRQ_N
);

// File: verif/ltc_line_model.sv
// Partner: coaxial line looped back to the monitor pins
`timescale 1ns/1ps
module ltc_line_model (
  // Line from the device
  input  wire logic tip,
  input  wire logic ring,
  input  wire logic tip_oe,
  input  wire logic ring_oe,
  // Cable cut
  input  wire logic cut,
  // Monitor pins
  output logic      mon_tip,
  output logic      mon_ring
);
  // ----
  // Termination pulls a released or cut line to zero
  // ----
  assign mon_tip  = tip_oe && !cut ? tip : 1'b0;
  assign mon_ring = ring_oe && !cut ? ring : 1'b0;
endmodule // ltc_line_model

// File: verif/ltc_top_bench.sv
// Testbench: register and line scenarios for the line control top
`timescale 1ns/1ps
module ltc_top_bench;
  localparam logic [15:0] TXA = ltc_pkg::TX_CTRL_ADDR;
  localparam logic [15:0] DRA = ltc_pkg::DRV_CTRL_ADDR;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        pin = 1'b1, cut = 1'b0, fpos = 1'b0, fneg = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata;
  logic        tip, ring, tip_oe, ring_oe, bo, irq_n, monitor_tip_in, monitor_ring_in;
  logic [1:0]  ph = 2'h0;
  int          n_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    fpos <= (ph == 2'h1);
    fneg <= (ph == 2'h3);
  end
  ltc_top ltc_top_inst (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .FRM_POS(fpos), .FRM_NEG(fneg),
    .DRV_EN_PIN(pin), .MON_TIP_IN(monitor_tip_in), .MON_RING_IN(monitor_ring_in),
    .TX_LINE_TIP_OUT(tip), .TX_LINE_RING_OUT(ring), .TX_LINE_TIP_OE(tip_oe),
    .TX_LINE_RING_OE(ring_oe), .BUILD_OUT_BYPASS(bo), .IRQ_N(irq_n));
  ltc_line_model ltc_line_model_inst (.tip(tip), .ring(ring),
    .tip_oe(tip_oe), .ring_oe(ring_oe), .cut(cut), .mon_tip(monitor_tip_in),
    .mon_ring(monitor_ring_in));
  // ----
  // Tasks
  // ----
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [15:0] a, logic [7:0] exp, string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic line_chk(logic aones, string what);
    logic p, n, t;
    repeat (4) begin
      @(posedge clk);
      p = fpos;
      n = fneg;
      t = tip;
      #1;
      chk(what, aones ? {6'h0, ~t, t} : {6'h0, p, n}, {6'h0, tip, ring});
    end
  endtask
  task automatic results;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    static logic [15:0] map [5] = '{ltc_pkg::DRV_CTRL_ADDR,
      ltc_pkg::ALM_STAT_ADDR, ltc_pkg::TX_CTRL_ADDR, ltc_pkg::IRQ_STAT_ADDR,
      ltc_pkg::IRQ_EN_ADDR};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (map[i]) rd_reg(map[i], 8'h00, "reset value");
    chk("irq_n", 8'h01, {7'h0, irq_n});
    wr_reg(TXA, 8'hFF);
    rd_reg(TXA, 8'h25, "tx ctrl");
    chk("bypass", 8'h01, {7'h0, bo});
    wr_reg(DRA, 8'hFF);
    rd_reg(DRA, 8'h01, "drv ctrl");
    wr_reg(16'h1305, 8'hFF);
    rd_reg(16'h1305, 8'h00, "unmapped");
    $display("test registers finished");
    wr_reg(TXA, 8'h00);
    repeat (3) @(posedge clk);
    chk("bypass", 8'h00, {7'h0, bo});
    line_chk(1'b0, "framer data");
    wr_reg(TXA, 8'h04);
    repeat (3) @(posedge clk);
    line_chk(1'b1, "all ones");
    @(posedge clk) pin <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("pin off", 8'h00, {4'h0, tip_oe, ring_oe, tip, ring});
    @(posedge clk) pin <= 1'b1;
    wr_reg(DRA, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("bit off", 8'h00, {4'h0, tip_oe, ring_oe, tip, ring});
    wr_reg(DRA, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk("driver on", 8'h03, {6'h0, tip_oe, ring_oe});
    $display("test line finished");
    wr_reg(ltc_pkg::IRQ_EN_ADDR, 8'h01);
    wr_reg(TXA, 8'h24);
    @(posedge clk) cut <= 1'b1;
    repeat (140) @(posedge clk);
    rd_reg(ltc_pkg::ALM_STAT_ADDR, 8'h00, "internal alarm");
    wr_reg(TXA, 8'h04);
    repeat (140) @(posedge clk);
    rd_reg(ltc_pkg::ALM_STAT_ADDR, 8'h01, "fault alarm");
    rd_reg(ltc_pkg::IRQ_STAT_ADDR, 8'h01, "fault status");
    chk("irq_n", 8'h00, {7'h0, irq_n});
    wr_reg(ltc_pkg::IRQ_EN_ADDR, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("irq_n masked", 8'h01, {7'h0, irq_n});
    wr_reg(ltc_pkg::IRQ_EN_ADDR, 8'h01);
    wr_reg(ltc_pkg::IRQ_CLR_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    rd_reg(ltc_pkg::IRQ_STAT_ADDR, 8'h00, "cleared status");
    chk("irq_n cleared", 8'h01, {7'h0, irq_n});
    @(posedge clk) cut <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(ltc_pkg::ALM_STAT_ADDR, 8'h00, "recovered alarm");
    rd_reg(ltc_pkg::IRQ_STAT_ADDR, 8'h01, "recovery status");
    $display("test monitor finished");
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule // ltc_top_bench
